// ===== rtl/spi_eeprom_defs.vh
// Constants for the serial EEPROM command front end
`ifndef SPI_EEPROM_DEFS_VH
`define SPI_EEPROM_DEFS_VH
`define OP_ARRAY_READ    8'h03
`define OP_ARRAY_WRITE   8'h02
`define OP_LATCH_CLEAR   8'h04
`define OP_LATCH_SET     8'h06
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_DONT_CARE_MSK 8'hF7
`define ADDR_W           7
`define PAGE_W           4
`define ST_BUSY_BIT      0
`define ST_LATCH_BIT     1
`define ST_GUARD_LO_BIT  2
`define ST_GUARD_HI_BIT  3
`define GUARD_RESET      2'h0
`define GUARD_QUARTER    7'h60
`define GUARD_HALF       7'h40
`define WRITE_TIME_NS    5000000
`define CLK_PERIOD_NS    100
`define FIFO_DEPTH       4
`endif

// ===== rtl/byte_fifo.v
// Small valid/ready FIFO with registered read data
`timescale 1ns/100ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             i_clk,
    input  wire             i_rstn,
    input  wire             i_flush,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg  [AW-1:0]    wr_r;
    reg  [AW-1:0]    rd_r;
    reg  [AW:0]      cnt_r;
    reg  [WIDTH-1:0] head_r;
    wire             push;
    wire             pop;
    wire [AW-1:0]    rd_next;

    assign o_in_ready  = (cnt_r != DEPTH[AW:0]);
    assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_data  = head_r;
    assign rd_next     = pop ? rd_r + 1'b1 : rd_r;

    // Head register tracks the word at the read pointer, taking a write to that slot in the same cycle
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_r   <= {AW{1'b0}};
            rd_r   <= {AW{1'b0}};
            cnt_r  <= {(AW+1){1'b0}};
            head_r <= {WIDTH{1'b0}};
        end else if (i_flush) begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            rd_r  <= rd_next;
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
            head_r <= (push && (wr_r == rd_next)) ? i_in_data : mem_r[rd_next];
        end
    end

    always @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_r] <= i_in_data;
        end
    end
endmodule // byte_fifo

// ===== rtl/spi_eeprom_core.v
// Serial EEPROM command front end: SPI decode, page buffer, array and status
// Behaviour
// - Shift opcode into 8-bit register on rising edges
// - All bytes travel MSb first
// - First bit sampled on first rise after select
// - Pause freezes sequence; release resumes it
// - Read opcode plus address streams array data
// - Read address increments, wraps 7Fh to 00h
// - Raising select ends a read
// - Latch sets only on deselect after opcode
// - Page write wraps within 16-byte page
// - Program only if deselect follows byte end
// - Status readable while busy; array reads fail
// - Finished write cycle clears the latch
// - Decode array read and write, bit 3 ignored
// - Decode latch set and latch clear
// - Decode status read and status write
// - Latch cleared by reset, commands, protect low
// - Status layout busy, latch, two guard bits
// - Busy flag high only during write cycle
// - Latch bit follows latch, even if protected
// - Guard bits change only by status write
// - No write without latch set beforehand
// - Guard codes protect none, quarter, half, all
// - Write cycle ends within 5 ms
// - Protect input low blocks every write
// - Serial output released while deselected
`timescale 1ns/100ps
`include "spi_eeprom_defs.vh"
module spi_eeprom_core #(
    parameter WRITE_CYCLES = (`WRITE_TIME_NS) / (`CLK_PERIOD_NS)
) (
    input  wire i_clk,
    input  wire i_rstn,
    input  wire i_sck,
    input  wire i_cs_n,
    input  wire i_si,
    input  wire i_pause_n,
    input  wire i_wp_n,
    output wire o_so,
    output wire o_so_oe_n
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [1:0] s1_r;
    reg [1:0] s2_r;
    reg [1:0] s3_r;
    reg [1:0] s4_r;
    reg [1:0] s5_r;
    reg       sck_d_r;
    reg       cs_d_r;
    wire sck_s  = s1_r[1];
    wire cs_s   = s2_r[1];
    wire si_s   = s3_r[1];
    wire hold_s = s4_r[1];
    wire wp_s   = s5_r[1];

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_r    <= 2'h0;
            s2_r    <= 2'h3;
            s3_r    <= 2'h0;
            s4_r    <= 2'h3;
            s5_r    <= 2'h3;
            sck_d_r <= 1'b0;
            cs_d_r  <= 1'b1;
        end else begin
            s1_r    <= {s1_r[0], i_sck};
            s2_r    <= {s2_r[0], i_cs_n};
            s3_r    <= {s3_r[0], i_si};
            s4_r    <= {s4_r[0], i_pause_n};
            s5_r    <= {s5_r[0], i_wp_n};
            sck_d_r <= sck_s;
            cs_d_r  <= cs_s;
        end
    end

    // Pause is taken while the clock is low and the device is selected
    reg  paused_r;
    wire rise   = sck_s & ~sck_d_r & ~cs_s & ~paused_r;
    wire fall   = ~sck_s & sck_d_r & ~cs_s & ~paused_r;
    wire cs_up  = cs_s & ~cs_d_r;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            paused_r <= 1'b0;
        end else if (cs_s) begin
            paused_r <= 1'b0;
        end else if (!sck_s) begin
            paused_r <= ~hold_s;
        end
    end

    // ****************************************
    // Opcode decode
    // ****************************************
    localparam S_OP   = 3'h0;
    localparam S_ADDR = 3'h1;
    localparam S_RD   = 3'h2;
    localparam S_WR   = 3'h3;
    localparam S_SRD  = 3'h4;
    localparam S_SWR  = 3'h5;
    localparam S_DONE = 3'h6;
    localparam S_IGN  = 3'h7;

    function op_is;
        input [7:0] op;
        input [7:0] code;
        begin
            op_is = ((op & `OP_DONT_CARE_MSK) == code);
        end
    endfunction

    function guarded;
        input [1:0]         g;
        input [`ADDR_W-1:0] a;
        begin
            case (g)
                2'h0:    guarded = 1'b0;
                2'h1:    guarded = (a >= `GUARD_QUARTER);
                2'h2:    guarded = (a >= `GUARD_HALF);
                default: guarded = 1'b1;
            endcase
        end
    endfunction

    reg [2:0]         st_r;
    reg [7:0]         sh_r;
    reg [2:0]         bit_r;
    reg [7:0]         op_r;
    reg [`ADDR_W-1:0] addr_r;
    reg               latch_r;
    reg               busy_r;
    reg [1:0]         guard_r;
    reg [7:0]         out_r;
    reg               so_r;
    reg               byte_end_r;
    reg               any_data_r;
    reg [7:0]         new_status_r;
    reg [22:0]        tmr_r;
    reg               prog_arr_r;
    reg               prog_st_r;
    reg [`ADDR_W-1:0] page_base_r;
    reg [`PAGE_W:0]   pend_r;
    reg [`PAGE_W-1:0] pidx_r;
    reg [7:0]         page_r [0:(1<<`PAGE_W)-1];
    reg [`PAGE_W:0]   drained_r;
    wire [7:0]        sh_in  = {sh_r[6:0], si_s};
    wire [7:0]        status = {4'h0, guard_r, latch_r, busy_r};
    wire [7:0]        mem_rd;

    // Array storage; read data registered
    reg [7:0]         arr_r [0:(1<<`ADDR_W)-1];
    reg [7:0]         arr_q_r;
    wire              f_valid;
    wire [7:0]        f_data;
    wire              f_in_ready;
    reg               f_push_r;
    reg [7:0]         f_wdata_r;
    reg [`ADDR_W-1:0] wr_addr_r;
    wire              f_pop = f_valid & prog_arr_r;

    always @(posedge i_clk) begin
        arr_q_r <= arr_r[addr_r];
        if (f_pop) begin
            arr_r[wr_addr_r] <= f_data;
        end
    end
    assign mem_rd = arr_q_r;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r       <= S_OP;
            sh_r       <= 8'h00;
            bit_r      <= 3'h0;
            op_r       <= 8'h00;
            addr_r     <= {`ADDR_W{1'b0}};
            out_r      <= 8'h00;
            so_r       <= 1'b0;
            byte_end_r <= 1'b0;
            any_data_r <= 1'b0;
            new_status_r <= 8'h00;
            page_base_r  <= {`ADDR_W{1'b0}};
            pend_r     <= {(`PAGE_W+1){1'b0}};
            pidx_r     <= {`PAGE_W{1'b0}};
        end else if (cs_s) begin
            st_r       <= S_OP;
            bit_r      <= 3'h0;
            if (!cs_up) begin
                byte_end_r <= 1'b0;
                any_data_r <= 1'b0;
                pend_r     <= busy_r ? pend_r : {(`PAGE_W+1){1'b0}};
            end
        end else if (rise) begin
            sh_r       <= sh_in;
            bit_r      <= bit_r + 3'h1;
            byte_end_r <= (bit_r == 3'h7);
            if (bit_r == 3'h7) begin
                case (st_r)
                    S_OP: begin
                        op_r <= sh_in;
                        if (op_is(sh_in, `OP_ARRAY_READ) || op_is(sh_in, `OP_ARRAY_WRITE)) begin
                            st_r <= S_ADDR;
                        end else if (op_is(sh_in, `OP_STATUS_READ)) begin
                            st_r  <= S_SRD;
                            out_r <= status;
                        end else if (op_is(sh_in, `OP_STATUS_WRITE)) begin
                            st_r <= S_SWR;
                        end else if (op_is(sh_in, `OP_LATCH_SET)
                                     || op_is(sh_in, `OP_LATCH_CLEAR)) begin
                            st_r <= S_DONE;
                        end else begin
                            st_r <= S_IGN;
                        end
                        if (busy_r && !op_is(sh_in, `OP_STATUS_READ)) begin
                            st_r <= S_IGN;
                        end
                    end
                    S_ADDR: begin
                        addr_r      <= sh_in[`ADDR_W-1:0];
                        page_base_r <= {sh_in[`ADDR_W-1:`PAGE_W], {`PAGE_W{1'b0}}};
                        pidx_r      <= sh_in[`PAGE_W-1:0];
                        if (op_is(op_r, `OP_ARRAY_WRITE)) begin
                            st_r <= S_WR;
                        end else if (busy_r) begin
                            st_r <= S_IGN;
                        end else begin
                            st_r <= S_RD;
                        end
                    end
                    S_RD: begin
                        addr_r <= addr_r + 1'b1;
                    end
                    S_WR: begin
                        page_r[pidx_r] <= sh_in;
                        pidx_r     <= pidx_r + 1'b1;
                        any_data_r <= 1'b1;
                        if (pend_r != (1 << `PAGE_W)) begin
                            pend_r <= pend_r + 1'b1;
                        end
                    end
                    S_SWR: begin
                        new_status_r <= sh_in;
                        any_data_r   <= 1'b1;
                        st_r         <= S_DONE;
                    end
                    S_SRD: begin
                        out_r <= status;
                    end
                    default: begin
                        st_r <= S_IGN;
                    end
                endcase
            end
        end else if (fall) begin
            // Output shifts after the falling clock edge
            if (bit_r == 3'h0 && st_r == S_RD) begin
                out_r <= mem_rd;
                so_r  <= mem_rd[7];
            end else if (bit_r == 3'h0 && st_r == S_SRD) begin
                so_r  <= status[7];
                out_r <= status;
            end else begin
                so_r  <= out_r[3'h7 - bit_r];
            end
        end
    end

    // Read data is presented in a read state; a low pause input releases it at once
    assign o_so      = so_r;
    assign o_so_oe_n = cs_s | paused_r | ~hold_s | ~((st_r == S_RD) | (st_r == S_SRD));

    // ****************************************
    // Latch, guard and write cycle
    // ****************************************
    wire end_ok   = cs_up & byte_end_r & (bit_r == 3'h0);
    wire wr_go    = end_ok & (st_r == S_WR) & any_data_r & latch_r & wp_s & ~busy_r
                    & ~guarded(guard_r, page_base_r);
    wire sw_go    = end_ok & (st_r == S_DONE) & any_data_r & op_is(op_r, `OP_STATUS_WRITE)
                    & latch_r & wp_s & ~busy_r;
    wire set_go   = end_ok & (st_r == S_DONE) & op_is(op_r, `OP_LATCH_SET) & ~busy_r;
    wire clr_go   = end_ok & (st_r == S_DONE) & op_is(op_r, `OP_LATCH_CLEAR) & ~busy_r;
    wire cyc_done = busy_r & (tmr_r == 23'h000000) & ~f_valid & ~f_push_r;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            latch_r    <= 1'b0;
            busy_r     <= 1'b0;
            guard_r    <= `GUARD_RESET;
            tmr_r      <= 23'h000000;
            prog_arr_r <= 1'b0;
            prog_st_r  <= 1'b0;
            drained_r  <= {(`PAGE_W+1){1'b0}};
            f_push_r   <= 1'b0;
            f_wdata_r  <= 8'h00;
            wr_addr_r  <= {`ADDR_W{1'b0}};
        end else begin
            f_push_r <= 1'b0;
            if (wr_go || sw_go) begin
                busy_r     <= 1'b1;
                tmr_r      <= WRITE_CYCLES[22:0] - 23'h000001;
                prog_arr_r <= wr_go;
                prog_st_r  <= sw_go;
                drained_r  <= {(`PAGE_W+1){1'b0}};
            end else if (busy_r) begin
                if (tmr_r != 23'h000000) begin
                    tmr_r <= tmr_r - 23'h000001;
                end
                // Page buffer streams into the array through the FIFO
                if (prog_arr_r && drained_r != pend_r && f_in_ready && !f_push_r) begin
                    f_push_r  <= 1'b1;
                    f_wdata_r <= page_r[(pidx_r - pend_r[`PAGE_W-1:0])
                                        + drained_r[`PAGE_W-1:0]];
                    drained_r <= drained_r + 1'b1;
                end
                if (f_pop) begin
                    wr_addr_r <= {wr_addr_r[`ADDR_W-1:`PAGE_W],
                                  wr_addr_r[`PAGE_W-1:0] + 1'b1};
                end
                if (cyc_done && drained_r == pend_r) begin
                    busy_r     <= 1'b0;
                    latch_r    <= 1'b0;
                    prog_arr_r <= 1'b0;
                    prog_st_r  <= 1'b0;
                    if (prog_st_r) begin
                        guard_r <= new_status_r[`ST_GUARD_HI_BIT:`ST_GUARD_LO_BIT];
                    end
                end
            end
            if (wr_go) begin
                // First byte lands at the start address when at most 16 bytes were sent; the rest wrap in the page
                wr_addr_r <= page_base_r
                             | {{(`ADDR_W-`PAGE_W){1'b0}}, pidx_r - pend_r[`PAGE_W-1:0]};
            end
            if (set_go) begin
                latch_r <= 1'b1;
            end
            if (clr_go || sw_go) begin
                latch_r <= 1'b0;
            end
            if (!wp_s) begin
                latch_r <= 1'b0;
            end
        end
    end

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (`FIFO_DEPTH),
        .AW    (2)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_flush     (1'b0),
        .i_in_valid  (f_push_r),
        .o_in_ready  (f_in_ready),
        .i_in_data   (f_wdata_r),
        .o_out_valid (f_valid),
        .i_out_ready (prog_arr_r),
        .o_out_data  (f_data)
    );
endmodule // spi_eeprom_core

// ===== verification/spi_host.sv
// SPI host model driving the serial EEPROM link pins
`timescale 1ns/100ps
module spi_host (
    input  wire i_clk,
    input  wire i_so,
    input  wire i_so_oe_n,
    output reg  o_sck,
    output reg  o_cs_n,
    output reg  o_si,
    output reg  o_pause_n
);
    reg last_r;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        o_pause_n = 1'b1;
        last_r = 1'b0;
    end
    // One phase of the 800 ns link clock, moved just after a system edge
    task half;
        begin
            repeat (4) @(posedge i_clk);
            #1;
        end
    endtask
    task sel;
        begin
            half;
            o_cs_n = 1'b0;
            half;
        end
    endtask
    task desel;
        begin
            half;
            o_cs_n = 1'b1;
            o_si = ~o_si;  // A released line must not keep its last level
            half;
            half;
        end
    endtask
    task xfer(input [7:0] tx, input pz, output [7:0] rx);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                o_si = tx[i];
                if (pz && i == 3) begin
                    o_pause_n = 1'b0;
                    repeat (3) half;
                    o_pause_n = 1'b1;
                end
                half;
                o_sck = 1'b1;
                rx[i] = i_so_oe_n ? ~last_r : i_so;  // Undriven SO reads as the inverse of the last bit
                last_r = rx[i];
                half;
                o_sck = 1'b0;
            end
        end
    endtask
endmodule  // spi_host

// ===== verification/spi_eeprom_props.sv
// Port checker for the serial EEPROM command front end
`timescale 1ns/100ps
module spi_eeprom_props #(
    parameter WRITE_CYCLES = 50000
) (
    input wire i_clk,
    input wire i_rstn,
    input wire i_sck,
    input wire i_cs_n,
    input wire i_si,
    input wire i_pause_n,
    input wire i_wp_n,
    input wire o_so,
    input wire o_so_oe_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    chk_reset_quiet: assert property ($rose(i_rstn) |-> o_so_oe_n [*3])
        else $error("serial output driven just after reset");
    chk_deselect_idle: assert property (i_cs_n [*5] |-> o_so_oe_n)
        else $error("serial output driven while deselected");
    chk_read_ends: assert property ($rose(i_cs_n) |-> ##[1:5] o_so_oe_n)
        else $error("read not ended by deselect");
    chk_pause_quiet: assert property (!i_pause_n [*5] |-> o_so_oe_n)
        else $error("serial output driven while paused");
    chk_drive_selected: assert property (!o_so_oe_n |-> !$past(i_cs_n, 5))
        else $error("serial output driven without select");
    chk_first_bit_edge: assert property ($fell(o_so_oe_n) |-> !$past(i_cs_n, 3) && $past(i_pause_n, 3))
        else $error("output enabled while deselected or paused");
    chk_so_fall_edge: assert property (!o_so_oe_n && $past(!o_so_oe_n) && $changed(o_so)
        |-> !$past(i_sck, 2))
        else $error("serial output moved after a rising link edge");
    chk_so_stands: assert property (i_sck [*3] ##0 !o_so_oe_n |-> $stable(o_so))
        else $error("serial output moved in the high clock phase");
    cover property ($fell(o_so_oe_n));
    cover property (!i_pause_n && !i_cs_n);
    cover property ($fell(i_wp_n));
endmodule  // spi_eeprom_props

// ===== verification/tb_top.sv
// Self-checking bench for the serial EEPROM command front end
`timescale 1ns/100ps
module tb_top;
    localparam WC = 600;
    reg        i_clk = 1'b0;
    reg        i_rstn = 1'b0;
    reg        i_wp_n = 1'b1;
    wire       sck, cs_n, si, pause_n, so, so_oe_n;
    reg  [7:0] mem [0:127];
    reg  [7:0] rx;
    reg  [7:0] d;
    integer    n_errors = 0;
    integer    cmp_count = 0;
    integer    seed = 59;
    integer    k;
    always #50 i_clk = ~i_clk;
    spi_eeprom_core #(.WRITE_CYCLES(WC)) uut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_pause_n(pause_n),
        .i_wp_n(i_wp_n), .o_so(so), .o_so_oe_n(so_oe_n));
    spi_host host (.i_clk(i_clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_sck(sck),
        .o_cs_n(cs_n), .o_si(si), .o_pause_n(pause_n));
    task check(input [7:0] got, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("errors=%0d compares=%0d", n_errors, cmp_count);
            if (n_errors == 0 && cmp_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task fr(input [7:0] a, input [7:0] b);
        begin
            host.sel;
            host.xfer(a, 1'b0, rx);
            host.xfer(b, 1'b0, rx);
            host.desel;
        end
    endtask
    task cmd(input [7:0] op);
        begin
            host.sel;
            host.xfer(op, 1'b0, rx);
            host.desel;
        end
    endtask
    task rd_status;
        begin
            d = $random(seed);
            fr(8'h05, d);
        end
    endtask
    task st(input [7:0] exp);
        begin
            rd_status;
            check(rx, exp);
        end
    endtask
    // Busy polling is bounded so a stuck write cycle ends the run
    task wait_idle;
        begin
            k = 0;
            rd_status;
            while (rx[0] !== 1'b0) begin
                k = k + 1;
                if (k > 20) begin
                    n_errors = n_errors + 1;
                    test_done;
                end
                rd_status;
            end
        end
    endtask
    // Page writes wrap inside their 16-byte page
    function [6:0] page_addr(input [6:0] a, input integer j);
        begin
            page_addr = {a[6:4], a[3:0] + j[3:0]};
        end
    endfunction
    task pw(input [6:0] a, input integer n, input ok);
        integer j;
        begin
            cmd(8'h06);
            host.sel;
            host.xfer(8'h02, 1'b0, rx);
            host.xfer({1'b0, a}, 1'b0, rx);
            for (j = 0; j < n; j = j + 1) begin
                d = $random(seed);
                host.xfer(d, 1'b0, rx);
                if (ok)
                    mem[page_addr(a, j)] = d;
            end
            host.desel;
        end
    endtask
    task rd(input [6:0] a, input integer n);
        integer j;
        begin
            host.sel;
            host.xfer(8'h03, 1'b0, rx);
            host.xfer({1'b0, a}, 1'b1, rx);
            for (j = 0; j < n; j = j + 1) begin
                d = $random(seed);
                host.xfer(d, j == 1, rx);
                check(rx, mem[a + j[6:0]]);
            end
            host.desel;
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (4) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        st(8'h00);
        cmd(8'h0E);
        st(8'h02);
        cmd(8'h04);
        st(8'h00);
        fr(8'h06, 8'h02);
        st(8'h00);
        fr(8'hFF, 8'h06);
        st(8'h00);
        pw(7'h7E, 18, 1'b1);
        st(8'h03);
        host.sel;
        host.xfer(8'h0B, 1'b0, rx);
        host.xfer(8'h70, 1'b0, rx);
        host.xfer(8'h3C, 1'b0, rx);
        check({7'h00, so_oe_n}, 8'h01);
        host.desel;
        wait_idle;
        st(8'h00);
        pw(7'h00, 16, 1'b1);
        wait_idle;
        pw(7'h0F, 2, 1'b1);
        wait_idle;
        rd(7'h7F, 3);
        rd(7'h70, 16);
        cmd(8'h06);
        fr(8'h02, 8'h20);
        rd_status;
        check(rx & 8'h01, 8'h00);
        cmd(8'h06);
        i_wp_n = 1'b0;
        st(8'h00);
        pw(7'h08, 2, 1'b0);
        wait_idle;
        rd(7'h08, 2);
        i_wp_n = 1'b1;
        cmd(8'h06);
        fr(8'h01, 8'h04);
        wait_idle;
        st(8'h04);
        pw(7'h72, 2, 1'b0);
        wait_idle;
        pw(7'h05, 1, 1'b1);
        wait_idle;
        rd(7'h70, 16);
        rd(7'h05, 1);
        cmd(8'h06);
        fr(8'h01, 8'h00);
        wait_idle;
        st(8'h00);
        test_done;
    end
endmodule  // tb_top
bind spi_eeprom_core spi_eeprom_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
    .i_pause_n(i_pause_n), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe_n(o_so_oe_n));
